// ==== logic/pci_bridge_mode_profiles.sv ====
`timescale 1ns/10ps
// Functional notes
// - Exactly one of three operating modes
// - Single-cycle profile sends all memory to np
// - Both master ports need pf and np regions
// - Master/target mode has master and access slave
// - Registers forced in host mode or translation
// - Any system master reaches the registers
// - Host mode offers the master/target profiles
// - Target profile always; master profile not target-only
// - Single-cycle: no RAM in target-only mode, only np port
// - Burst: pf via buffers, np single-cycle
// - Single-cycle and one-pending burst: one delayed read at a time
// - Multiple profile allows four delayed reads
// - Master single profile: one PCI read
// - Master profiles use RAM buffers
// - Master multiple profile: four PCI reads
// - Main reset all; second reset spares bridge
// - Shared clock option means one clock
// - Independent option adds PCI-side clock input
// - Non-prefetchable port never issues bursts
// - Target-only mode has no access slave
module pci_bridge_mode_profiles
   import bridge_pkg::*;
(
   input  wire logic        clk,           // System clock
   input  wire logic        rst,           // Async reset, high
   input  wire logic        hsel,          // AHB slave select
   input  wire logic [31:0] haddr,         // AHB address
   input  wire logic [1:0]  htrans,        // AHB transfer type
   input  wire logic        hwrite,        // AHB write
   input  wire logic [2:0]  hsize,         // AHB size, words only
   input  wire logic        hready,        // AHB bus ready
   input  wire logic [31:0] hwdata,        // AHB write data
   output logic      [31:0] hrdata,        // AHB read data
   output logic             hreadyout,     // Slave ready
   output logic             hresp,         // Always OKAY
   input  wire logic        pci_clk,       // PCI clock, sampled
   input  wire logic        pci_req_vld,   // PCI target request present
   input  wire pci_req_t    pci_req,       // PCI target request info
   input  wire logic        tgt_rd_cpl,    // Delayed read completed, pulse
   output logic             pf_req,        // Request to pf port, pulse
   output logic             np_req,        // Request to np port, pulse
   output pci_req_t         req_info,      // Info for routed request
   output logic             tgt_accept,    // Request taken, pulse
   output logic             tgt_retry,     // Retry PCI master, pulse
   input  wire logic        mst_req_vld,   // System request to PCI
   input  wire logic        mst_req_rd,    // System request is a read
   output logic             mst_ready,     // System request taken
   input  wire logic        mst_cpl_tgl,   // PCI read done, toggles
   input  wire logic        sys_rst_n_pin, // Second reset, low
   output logic             others_rst_n,  // Reset for all but bridge
   output port_en_t         port_en,       // Instantiated ports
   output logic             clk_indep,     // Independent clocks
   output logic             cfg_err        // Region set inconsistent
);

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic              pclk_prev_q;
   logic              cpl_prev_q;
   mode_t             mode_q;
   logic [1:0]        tprof_q;
   logic              mprof_q;
   logic              csr_opt_q;
   logic              xlat_q;
   logic              indclk_q;
   logic              indrst_q;
   logic [5:0]        pf_mask_q;
   logic [5:0]        mem_mask_q;
   logic [31:0]       retry_cnt_q;
   logic [2:0]        tgt_used_q;
   logic [2:0]        mst_used_q;
   logic              dph_wr_q;
   logic [7:0]        dph_addr_q;
   logic [31:0]       hrdata_q;
   logic              pf_req_q;
   logic              np_req_q;
   pci_req_t          req_info_q;
   logic              tgt_accept_q;
   logic              tgt_retry_q;
   pci_req_t          req_s;
   logic              samp;
   logic              cpl_evt;
   logic [7:0]        mem8;
   logic [7:0]        pf8;
   logic              hit;
   logic              route_pf;
   logic [2:0]        tgt_limit;
   logic [2:0]        mst_limit;
   logic              tgt_full;
   logic              alloc;
   logic              free;
   logic              full_retry;
   logic              mst_take;
   logic              aph;
   logic              wr_ctrl;
   logic [1:0]        wmode;
   logic [1:0]        wtprof;
   logic [1:0]        mode_enc;
   logic [31:0]       rd_mux;

   // Two flops on every pin from the PCI side; only the second stage is read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {sys_rst_n_pin, mst_cpl_tgl, pci_req, pci_req_vld, pci_clk};
         sync_q <= meta_q;
      end
   end

   // Edge history of the synchronised PCI clock and completion toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pclk_prev_q <= 1'b0;
         cpl_prev_q  <= 1'b0;
      end else begin
         pclk_prev_q <= sync_q[0];
         cpl_prev_q  <= sync_q[7];
      end
   end

   // Sample at the PCI falling edge, mid-cycle, when request pins are settled
   assign samp    = pclk_prev_q & ~sync_q[0] & sync_q[1];
   assign req_s   = pci_req_t'(sync_q[6:2]);
   assign cpl_evt = sync_q[7] ^ cpl_prev_q;

   // Second reset holds the rest of the system but never the bridge
   assign others_rst_n = ~rst & (~indrst_q | sync_q[8]);
   assign clk_indep    = indclk_q;

   // Derived structure of the bridge
   assign mem8 = {2'b00, mem_mask_q};
   assign pf8  = {2'b00, pf_mask_q};
   always_comb begin
      port_en.pf  = (tprof_q != TPROF_SINGLE) && |(pf_mask_q & mem_mask_q);
      port_en.np  = 1'b1;
      port_en.bas = (mode_q != MODE_TGT);
      port_en.ram = (tprof_q != TPROF_SINGLE) || (mode_q != MODE_TGT);
      port_en.csr = csr_opt_q || (mode_q == MODE_HOST) || xlat_q;
   end
   assign cfg_err = port_en.pf && !(|(~pf_mask_q & mem_mask_q));

   // Limits: master profile only matters once the access slave exists
   assign tgt_limit = (tprof_q == TPROF_BURSTN) ? PEND_MULTI : PEND_ONE;
   assign mst_limit = mprof_q ? PEND_MULTI : PEND_ONE;

   // Target request classification
   assign hit        = samp && mem8[req_s.bar];
   assign route_pf   = (tprof_q != TPROF_SINGLE) && pf8[req_s.bar];
   assign tgt_full   = (tgt_used_q >= tgt_limit);
   assign alloc      = hit && req_s.read && !tgt_full;
   assign free       = tgt_rd_cpl && (tgt_used_q != 3'h0);
   assign full_retry = hit && req_s.read && tgt_full;

   // Route a request: reads are always retried and finish as delayed reads
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pf_req_q     <= 1'b0;
         np_req_q     <= 1'b0;
         tgt_accept_q <= 1'b0;
         tgt_retry_q  <= 1'b0;
         req_info_q   <= '0;
      end else begin
         pf_req_q     <= hit && (alloc || !req_s.read) && route_pf;
         np_req_q     <= hit && (alloc || !req_s.read) && !route_pf;
         tgt_accept_q <= hit && (alloc || !req_s.read);
         tgt_retry_q  <= hit && req_s.read;
         if (hit) begin
            req_info_q       <= req_s;
            req_info_q.burst <= req_s.burst && route_pf;
         end
      end
   end

   // Delayed read slots in use; allocate and free in one cycle cancel out
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgt_used_q <= 3'h0;
      end else begin
         case ({alloc, free})
            2'b10:   tgt_used_q <= tgt_used_q + 3'h1;
            2'b01:   tgt_used_q <= tgt_used_q - 3'h1;
            default: tgt_used_q <= tgt_used_q;
         endcase
      end
   end

   // Master side: reads wait for a free outstanding slot
   assign mst_ready = port_en.bas && (!mst_req_rd || (mst_used_q < mst_limit));
   assign mst_take  = mst_req_vld && mst_ready && mst_req_rd;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mst_used_q <= 3'h0;
      end else begin
         case ({mst_take, cpl_evt && (mst_used_q != 3'h0)})
            2'b10:   mst_used_q <= mst_used_q + 3'h1;
            2'b01:   mst_used_q <= mst_used_q - 3'h1;
            default: mst_used_q <= mst_used_q;
         endcase
      end
   end

   // AHB-Lite slave: zero wait states, any master may reach it
   assign aph       = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   assign wr_ctrl   = dph_wr_q && (dph_addr_q == CTRL_OFS);
   assign wmode     = hwdata[CTRL_MODE_LSB +: 2];
   assign wtprof    = hwdata[CTRL_TPROF_LSB +: 2];

   // Address phase capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dph_wr_q   <= 1'b0;
         dph_addr_q <= 8'h00;
      end else begin
         dph_wr_q   <= aph && hwrite;
         dph_addr_q <= haddr[7:0];
      end
   end

   // Encoded mode for readback
   always_comb begin
      case (mode_q)
         MODE_MT:   mode_enc = MODE_ENC_MT;
         MODE_HOST: mode_enc = MODE_ENC_HOST;
         default:   mode_enc = MODE_ENC_TGT;
      endcase
   end

   // Read data chosen in the address phase, so it stands in the data phase
   always_comb begin
      if (haddr[7:0] == CTRL_OFS) begin
         rd_mux = {23'h00_0000, indrst_q, indclk_q, xlat_q, csr_opt_q, mprof_q,
                   tprof_q, mode_enc};
      end else if (haddr[7:0] == BAR_OFS) begin
         rd_mux = {18'h0_0000, mem_mask_q, 2'b00, pf_mask_q};
      end else if (haddr[7:0] == STAT_OFS) begin
         rd_mux = {20'h0_0000, cfg_err, mst_used_q, tgt_used_q, port_en};
      end else if (haddr[7:0] == RETRY_OFS) begin
         rd_mux = retry_cnt_q;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_q <= 32'h0000_0000;
      end else if (aph && !hwrite) begin
         hrdata_q <= rd_mux;
      end
   end

   // Control register; reserved encodings are refused so one mode always holds
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q    <= MODE_TGT;
         tprof_q   <= CTRL_RST[CTRL_TPROF_LSB +: 2];
         mprof_q   <= CTRL_RST[CTRL_MPROF_BIT];
         csr_opt_q <= CTRL_RST[CTRL_CSR_BIT];
         xlat_q    <= CTRL_RST[CTRL_XLAT_BIT];
         indclk_q  <= CTRL_RST[CTRL_INDCLK_BIT];
         indrst_q  <= CTRL_RST[CTRL_INDRST_BIT];
      end else if (wr_ctrl) begin
         if (wmode == MODE_ENC_TGT) begin
            mode_q <= MODE_TGT;
         end else if (wmode == MODE_ENC_MT) begin
            mode_q <= MODE_MT;
         end else if (wmode == MODE_ENC_HOST) begin
            mode_q <= MODE_HOST;
         end
         if (wtprof != 2'h3) begin
            tprof_q <= wtprof;
         end
         mprof_q   <= hwdata[CTRL_MPROF_BIT];
         csr_opt_q <= hwdata[CTRL_CSR_BIT];
         xlat_q    <= hwdata[CTRL_XLAT_BIT];
         indclk_q  <= hwdata[CTRL_INDCLK_BIT];
         indrst_q  <= hwdata[CTRL_INDRST_BIT];
      end
   end

   // Region masks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pf_mask_q  <= BAR_RST[BAR_PF_LSB +: BAR_NUM];
         mem_mask_q <= BAR_RST[BAR_MEM_LSB +: BAR_NUM];
      end else if (dph_wr_q && (dph_addr_q == BAR_OFS)) begin
         pf_mask_q  <= hwdata[BAR_PF_LSB +: BAR_NUM];
         mem_mask_q <= hwdata[BAR_MEM_LSB +: BAR_NUM];
      end
   end

   // Retries due to full slots; a count in the clearing cycle is kept
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         retry_cnt_q <= 32'h0000_0000;
      end else if (full_retry) begin
         retry_cnt_q <= (dph_wr_q && (dph_addr_q == RETRY_OFS)) ? 32'h0000_0001
                                                                : retry_cnt_q + 32'h0000_0001;
      end else if (dph_wr_q && (dph_addr_q == RETRY_OFS)) begin
         retry_cnt_q <= 32'h0000_0000;
      end
   end

   assign pf_req     = pf_req_q;
   assign np_req     = np_req_q;
   assign req_info   = req_info_q;
   assign tgt_accept = tgt_accept_q;
   assign tgt_retry  = tgt_retry_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_single_np;
      (hit && tprof_q == TPROF_SINGLE && !req_s.read) |=> (np_req && !pf_req);
   endproperty
   a_single_np: assert property (p_single_np) else $error("single profile used pf");

   property p_np_no_burst;
      np_req |-> !req_info.burst;
   endproperty
   a_np_no_burst: assert property (p_np_no_burst) else $error("np burst");

   property p_tgt_only;
      (mode_q == MODE_TGT) |-> (!mst_ready && !port_en.bas);
   endproperty
   a_tgt_only: assert property (p_tgt_only) else $error("master in target-only");

   property p_slot_limit;
      tgt_used_q <= tgt_limit || $past(tgt_limit) != tgt_limit;
   endproperty
   a_slot_limit: assert property (p_slot_limit) else $error("too many delayed reads");

   property p_single_pending;
      (tprof_q == TPROF_BURST1 && tgt_used_q == 3'h1 && hit && req_s.read && !free)
         |=> (tgt_retry && !tgt_accept) ##1 !tgt_retry;
   endproperty
   a_single_pending: assert property (p_single_pending) else $error("second read taken");

   property p_retry_full;
      full_retry |=> (tgt_retry && !pf_req && !np_req);
   endproperty
   a_retry_full: assert property (p_retry_full) else $error("full read not retried");

   property p_csr_forced;
      (mode_q == MODE_HOST || xlat_q) |-> port_en.csr;
   endproperty
   a_csr_forced: assert property (p_csr_forced) else $error("register block missing");

   property p_mst_single;
      (!mprof_q && mst_used_q == 3'h1 && mst_req_rd) |-> !mst_ready;
   endproperty
   a_mst_single: assert property (p_mst_single) else $error("second master read");

   property p_mst_limit;
      (mst_take && mst_used_q == 3'h3 && !cpl_evt) |=> (mst_used_q == 3'h4 && !mst_ready
                                                       || !mst_req_rd || !mprof_q);
   endproperty
   a_mst_limit: assert property (p_mst_limit) else $error("master slots wrong");

   property p_ctrl_mode;
      (wr_ctrl && wmode == MODE_ENC_HOST) |=> (mode_q == MODE_HOST) ##1 port_en.csr;
   endproperty
   a_ctrl_mode: assert property (p_ctrl_mode) else $error("mode write lost");

   property p_single_res;
      (tprof_q == TPROF_SINGLE && mode_q == MODE_TGT) |-> (!port_en.ram && !port_en.pf);
   endproperty
   a_single_res: assert property (p_single_res) else $error("single profile uses RAM");

   c_pf_req:    cover property (pf_req && req_info.burst);
   c_full:      cover property (full_retry);
   c_mst_read:  cover property (mst_take ##[1:200] cpl_evt);
   c_host_mode: cover property (mode_q == MODE_HOST && tgt_used_q == 3'h4);

endmodule // pci_bridge_mode_profiles

// ==== logic/bridge_pkg.sv ====
package bridge_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] BAR_OFS   = 8'h04;
   localparam logic [7:0] STAT_OFS  = 8'h08;
   localparam logic [7:0] RETRY_OFS = 8'h0C;

   // Control register field positions
   localparam int CTRL_MODE_LSB   = 0;   // Two bits, encoded operating mode
   localparam int CTRL_TPROF_LSB  = 2;   // Two bits, target profile
   localparam int CTRL_MPROF_BIT  = 4;   // Master profile, 1 = multiple pending
   localparam int CTRL_CSR_BIT    = 5;   // Optional register block wanted
   localparam int CTRL_XLAT_BIT   = 6;   // Dynamic system-to-PCI translation
   localparam int CTRL_INDCLK_BIT = 7;   // Independent clocks selected
   localparam int CTRL_INDRST_BIT = 8;   // Independent second reset enabled

   // Region register field positions (six base regions)
   localparam int BAR_PF_LSB  = 0;       // Prefetchable mask
   localparam int BAR_MEM_LSB = 8;       // Memory region mask
   localparam int BAR_NUM     = 6;

   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] BAR_RST  = 32'h0000_0302;

   // Encodings held in the control register
   localparam logic [1:0] MODE_ENC_TGT  = 2'h0;
   localparam logic [1:0] MODE_ENC_MT   = 2'h1;
   localparam logic [1:0] MODE_ENC_HOST = 2'h2;
   localparam logic [1:0] TPROF_SINGLE  = 2'h0;
   localparam logic [1:0] TPROF_BURST1  = 2'h1;
   localparam logic [1:0] TPROF_BURSTN  = 2'h2;

   // Pending read limits
   localparam logic [2:0] PEND_ONE   = 3'h1;
   localparam logic [2:0] PEND_MULTI = 3'h4;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam int         SYNC_W        = 9;

   typedef enum logic [2:0] {
      MODE_TGT  = 3'b001,
      MODE_MT   = 3'b010,
      MODE_HOST = 3'b100
   } mode_t;

   typedef struct packed {
      logic       read;   // Read request, else write
      logic       burst;  // Burst requested on PCI
      logic [2:0] bar;    // Base region hit
   } pci_req_t;

   typedef struct packed {
      logic pf;    // Prefetchable master port
      logic np;    // Non-prefetchable master port
      logic bas;   // PCI bus access slave port
      logic ram;   // Embedded RAM buffers
      logic csr;   // Register block
   } port_en_t;
endpackage

// ==== verif/pci_far_end.sv ====
`timescale 1ns/10ps
module pci_far_end
   import bridge_pkg::*;
(
   output logic     pci_clk,     // Link clock, still between frames
   output logic     pci_req_vld, // Target request present
   output pci_req_t pci_req,     // Target request info
   output logic     mst_cpl_tgl  // Master read finished, toggles
);
   // Idle link: clock parked low, no request
   initial begin
      pci_clk = 1'b0;
      pci_req_vld = 1'b0;
      pci_req = '0;
      mst_cpl_tgl = 1'b0;
   end

   // One request per link period; gap sets how slowly the far side starts
   task automatic frame(input logic rd, input logic bst, input logic [2:0] b, input realtime gap);
      #(gap);
      pci_req_vld = 1'b1;
      pci_req = '{read: rd, burst: bst, bar: b};
      #80 pci_clk = 1'b1;
      #80 pci_clk = 1'b0;
      #80 pci_req_vld = 1'b0;
      // Stale info is inverted so it cannot pass for a held value
      pci_req = pci_req_t'(~pci_req);
   endtask

   // A finished master read is signalled within one link period
   task automatic done_rd;
      #80 pci_clk = 1'b1;
      mst_cpl_tgl = ~mst_cpl_tgl;
      #80 pci_clk = 1'b0;
   endtask
endmodule // pci_far_end

// ==== verif/pci_bridge_mode_profiles_tb_top.sv ====
`timescale 1ns/10ps
module pci_bridge_mode_profiles_tb_top import bridge_pkg::*;;
   logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp, pci_clk, pci_req_vld;
   logic        tgt_rd_cpl, pf_req, np_req, tgt_accept, tgt_retry, mst_req_vld, mst_req_rd;
   logic        mst_ready, mst_cpl_tgl, sys_rst_n_pin, others_rst_n, clk_indep, cfg_err;
   logic        np_burst;
   logic [31:0] haddr, hwdata, hrdata, rd, v, bar, ctl, ex;
   logic [31:0] tbl [4];
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   pci_req_t    pci_req, req_info, last_info;
   port_en_t    port_en;
   int          miscompares, checks_done, cyc, n_pf, n_np, n_acc, n_ret, seed;

   assign hready = hreadyout;

   pci_bridge_mode_profiles i_pci_bridge_mode_profiles (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pci_clk(pci_clk), .pci_req_vld(pci_req_vld), .pci_req(pci_req),
      .tgt_rd_cpl(tgt_rd_cpl), .pf_req(pf_req), .np_req(np_req), .req_info(req_info),
      .tgt_accept(tgt_accept), .tgt_retry(tgt_retry), .mst_req_vld(mst_req_vld),
      .mst_req_rd(mst_req_rd), .mst_ready(mst_ready), .mst_cpl_tgl(mst_cpl_tgl),
      .sys_rst_n_pin(sys_rst_n_pin), .others_rst_n(others_rst_n), .port_en(port_en),
      .clk_indep(clk_indep), .cfg_err(cfg_err));

   pci_far_end i_pci_far_end (.pci_clk(pci_clk), .pci_req_vld(pci_req_vld),
      .pci_req(pci_req), .mst_cpl_tgl(mst_cpl_tgl));

   // 250 MHz system clock
   initial clk = 1'b0;
   always #2 clk = ~clk;

   // Pulse counters; single-cycle pulses are only seen at the edge they stand
   always @(posedge clk) begin
      n_pf <= n_pf + (pf_req === 1'b1);
      n_np <= n_np + (np_req === 1'b1);
      n_acc <= n_acc + (tgt_accept === 1'b1);
      n_ret <= n_ret + (tgt_retry === 1'b1);
      if (np_req === 1'b1) np_burst <= req_info.burst;
      if (tgt_accept === 1'b1) last_info <= req_info;
   end

   task automatic finish_test;
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Hang guard, far above the thousand or so cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One single AHB-Lite word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk("hresp", 32'(hresp), 32'h0);
   endtask

   // Expected STATUS: port set, zero slots, consistency flag
   function automatic logic [31:0] exp_stat(input logic [31:0] c, input logic [31:0] b);
      logic       pf;
      logic [4:0] pe;
      pf = (c[3:2] != TPROF_SINGLE) && ((b[5:0] & b[13:8]) != 6'h00);
      pe = {pf, 1'b1, c[1:0] != MODE_ENC_TGT, (c[3:2] != TPROF_SINGLE) ||
            (c[1:0] != MODE_ENC_TGT), c[5] | c[6] | (c[1:0] == MODE_ENC_HOST)};
      return {20'h0_0000, pf && ((~b[5:0] & b[13:8]) == 6'h00), 6'h00, pe};
   endfunction

   // One link request; e packs the expected pulse counts {pf, np, accept, retry}
   task automatic pci(input logic r, input logic [2:0] b, input logic [15:0] e);
      int p0, p1, p2, p3;
      p0 = n_pf;
      p1 = n_np;
      p2 = n_acc;
      p3 = n_ret;
      i_pci_far_end.frame(r, 1'b1, b, (b == 3'h0) ? 37.1 : 1.3);
      @(posedge clk);
      chk("pci_pulses", {16'h0000, 4'(n_pf - p0), 4'(n_np - p1), 4'(n_acc - p2),
          4'(n_ret - p3)}, {16'h0000, e});
      // Routed info carries bar and kind; burst only survives on the pf route
      if (e[4]) chk("req_info", 32'(last_info), 32'({r, e[12], b}));
   endtask

   task automatic cpl;
      @(posedge clk);
      tgt_rd_cpl <= 1'b1;
      @(posedge clk);
      tgt_rd_cpl <= 1'b0;
   endtask

   // System request toward the link, offered for one cycle
   task automatic mst(input logic r, input logic e);
      @(posedge clk);
      mst_req_vld <= 1'b1;
      mst_req_rd <= r;
      @(negedge clk);
      chk("mst_ready", 32'(mst_ready), 32'(e));
      @(posedge clk);
      mst_req_vld <= 1'b0;
   endtask

   // Main sequence
   initial begin
      {hsel, hwrite, tgt_rd_cpl, mst_req_vld, mst_req_rd, np_burst} = '0;
      {miscompares, checks_done, cyc, n_pf, n_np, n_acc, n_ret} = '0;
      {haddr, hwdata} = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      sys_rst_n_pin = 1'b1;
      seed = 165;
      tbl = '{32'h0000_0002, 32'h0000_0040, 32'h0000_0009, 32'h0000_0006};
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      ahb(0, CTRL_OFS, 32'h0);
      chk("ctrl_rst", rd, CTRL_RST);
      ahb(0, BAR_OFS, 32'h0);
      chk("bar_rst", rd, BAR_RST);
      ahb(0, STAT_OFS, 32'h0);
      chk("stat_rst", rd, 32'h0000_0008);
      ahb(0, 8'h10, 32'h0);
      chk("unmapped", rd, 32'h0000_0000);
      // Fixed corners first, then random settings of mode, profiles and regions
      for (int i = 0; i < 16; i++) begin
         v = $random(seed);
         ctl = {23'h00_0000, v[8:4], (v[3:2] == 2'h3) ? TPROF_BURST1 : v[3:2],
                (v[1:0] == 2'h3) ? MODE_ENC_MT : v[1:0]};
         bar = {18'h0_0000, v[21:16], 2'h0, v[29:24]};
         if (i < 4) ctl = tbl[i];
         if (i < 4) bar = BAR_RST;
         ahb(1, CTRL_OFS, ctl);
         ahb(1, BAR_OFS, bar);
         ahb(0, STAT_OFS, 32'h0);
         ex = exp_stat(ctl, bar);
         chk("stat", rd & 32'h0000_081F, ex);
         chk("port_en", {20'h0_0000, cfg_err, 6'h00, port_en}, ex);
         chk("clk_indep", 32'(clk_indep), 32'(ctl[7]));
      end
      // Mode code 3 and target profile 3 are refused, the old values stay
      ahb(1, CTRL_OFS, 32'h0000_0005);
      ahb(1, CTRL_OFS, 32'h0000_000F);
      ahb(0, CTRL_OFS, 32'h0);
      chk("ctrl_mode3", rd, 32'h0000_0005);
      ahb(1, BAR_OFS, BAR_RST);
      // Single-cycle: prefetchable hit still goes out as np, no burst, one slot
      ahb(1, CTRL_OFS, 32'h0000_0000);
      pci(1, 3'h1, 16'h0111);
      chk("np_burst", 32'(np_burst), 32'h0);
      pci(0, 3'h1, 16'h0110);
      pci(1, 3'h1, 16'h0001);
      ahb(0, RETRY_OFS, 32'h0);
      chk("retry_cnt", rd, 32'h0000_0001);
      ahb(1, RETRY_OFS, 32'h0);
      ahb(0, RETRY_OFS, 32'h0);
      chk("retry_clr", rd, 32'h0000_0000);
      cpl();
      // Burst with one pending read: writes pass, second read waits
      ahb(1, CTRL_OFS, 32'h0000_0004);
      pci(0, 3'h1, 16'h1010);
      pci(1, 3'h0, 16'h0111);
      pci(1, 3'h1, 16'h0001);
      cpl();
      // Burst with multiple pending reads: four slots, fifth retried
      ahb(1, CTRL_OFS, 32'h0000_0008);
      repeat (4) pci(1, 3'h1, 16'h1011);
      pci(1, 3'h1, 16'h0001);
      ahb(0, STAT_OFS, 32'h0);
      chk("slots", 32'(rd[7:5]), 32'h4);
      repeat (4) cpl();
      ahb(0, STAT_OFS, 32'h0);
      chk("slots_free", 32'(rd[7:5]), 32'h0);
      pci(1, 3'h2, 16'h0000);
      // Master side: none in target-only, one or four reads outstanding
      ahb(1, CTRL_OFS, 32'h0000_0000);
      mst(1, 0);
      ahb(1, CTRL_OFS, 32'h0000_0001);
      mst(1, 1);
      mst(1, 0);
      mst(0, 1);
      i_pci_far_end.done_rd();
      mst(1, 1);
      i_pci_far_end.done_rd();
      ahb(1, CTRL_OFS, 32'h0000_0011);
      repeat (4) mst(1, 1);
      mst(1, 0);
      repeat (4) i_pci_far_end.done_rd();
      mst(1, 1);
      // Second reset spares the bridge; main reset clears everything
      ahb(1, CTRL_OFS, 32'h0000_0104);
      sys_rst_n_pin <= 1'b0;
      repeat (4) @(posedge clk);
      chk("others_low", 32'(others_rst_n), 32'h0);
      ahb(0, CTRL_OFS, 32'h0);
      chk("ctrl_kept", rd, 32'h0000_0104);
      sys_rst_n_pin <= 1'b1;
      repeat (4) @(posedge clk);
      chk("others_high", 32'(others_rst_n), 32'h1);
      rst <= 1'b1;
      @(negedge clk);
      chk("others_rst", 32'(others_rst_n), 32'h0);
      // Hold reset across a rising edge, then release just after one
      @(posedge clk);
      rst <= 1'b0;
      ahb(0, CTRL_OFS, 32'h0);
      chk("ctrl_rst2", rd, CTRL_RST);
      finish_test();
   end
endmodule // pci_bridge_mode_profiles_tb_top
